// [logic/fspc_consts.svh]
/*
 * constants for the flash self-programming controller: register offsets,
 * control bit positions, command codes, window lengths and geometry.
 * assumes one 40 mhz clock and an apb register port.
 */
// Summary of operation
// - reset vector follows boot-reset fuse value
// - control register 8 bits, bit5 zero, bit6 read-only
// - ready interrupt while enable, global flag, store clear
// - erase/write to concurrent section sets busy flag
// - busy clears by re-enable or buffer load
// - re-enable unblocks only when no operation running
// - re-enable during buffer loading discards buffer
// - lock-set store programs lock bits from low data
// - load within three cycles returns lock or fuse
// - page write stores buffer to pointer page
// - page erase erases pointer page
// - halting section operation stalls processor core
// - plain store enable loads buffer word
// - store enable arms four clocks, auto-clears
// - undefined low five bit codes ignored
// - target page latched at operation start
// - load uses word-in-page field for buffer word
// - buffer clears after write, re-enable, reset; write-once
// - data-eeprom write discards loaded buffer
// - readback uses pointer bits 0 and 1 only; lock-set ignores pointer
// - page write code is write bit plus enable
// - eeprom write blocks programming and fuse readback
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH
// apb byte offsets
`define FSPC_OFS_CTRL 12'h000
`define FSPC_OFS_PTR 12'h004
`define FSPC_OFS_DATA 12'h008
`define FSPC_OFS_LOCK 12'h00c
`define FSPC_OFS_STAT 12'h010
`define FSPC_OFS_LOAD 12'h014
// control bit positions
`define FSPC_B_IE 7
`define FSPC_B_BUSY 6
`define FSPC_B_REEN 4
`define FSPC_B_LSET 3
`define FSPC_B_PWR 2
`define FSPC_B_PER 1
`define FSPC_B_EN 0
// low five bit command codes
`define FSPC_CMD_LOAD 5'h01
`define FSPC_CMD_ERASE 5'h03
`define FSPC_CMD_WRITE 5'h05
`define FSPC_CMD_LSET 5'h09
`define FSPC_CMD_REEN 5'h11
`define FSPC_CTRL_RST 8'h00
`define FSPC_LOCK_RST 8'hff
// windows in clocks
`define FSPC_STORE_WIN 3'h4
`define FSPC_LOAD_WIN 3'h3
// geometry: 64-word pages, 128 pages
`define FSPC_WORD_LSB 1
`define FSPC_WORD_W 6
`define FSPC_PAGE_LSB 7
`define FSPC_PAGE_W 7
`define FSPC_HALT_PAGE 7'h70
`define FSPC_BOOT_ADDR 16'h1c00
`define FSPC_RESET_ADDR 16'h0000
// programming time in ns and derived clocks
`define FSPC_PROG_NS 3700000
`define FSPC_CLK_NS 25
`define FSPC_PROG_CYC (`FSPC_PROG_NS / `FSPC_CLK_NS)
`endif

// [logic/fspc_pkg.sv]
/*
 * types for the flash self-programming controller.
 * assumes nothing beyond the constants header.
 */
`default_nettype none
package fspc_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        FSPC_IDLE = 2'b00,   // waiting
        FSPC_ARMED = 2'b01,  // store enable window open
        FSPC_BUSY = 2'b10    // erase or write running
    } fspc_state_e;
    typedef logic [15:0] fspc_word_t;
endpackage
`default_nettype wire

// [logic/fspc_buf_if.sv]
/*
 * carrier between controller and its page buffer memory.
 * assumes one clock shared by both ends.
 */
`default_nettype none
interface fspc_buf_if;
    logic wr;         // write one word
    logic clr;        // clear whole buffer
    logic [5:0] wa;   // write word index
    logic [15:0] wd;  // write data
    logic [5:0] ra;   // read word index
    logic [15:0] rd;  // registered read data
    logic used;       // addressed word already written
    modport ctrl(output wr, clr, wa, wd, ra, input rd, used);
    modport mem(input wr, clr, wa, wd, ra, output rd, used);
endinterface
`default_nettype wire

// [logic/fspc_page_buf.sv]
/*
 * page buffer: 64 words with a written-once marker per word.
 * assumes synchronous active-high reset; read data registered.
 */
`default_nettype none
`include "fspc_consts.svh"
module fspc_page_buf (
    input wire logic core_clk_i,  // system clock
    input wire logic sys_rst_i,   // sync reset
    fspc_buf_if.mem b             // buffer port
);
    logic [15:0] mem [0:63];      // word store
    logic [63:0] used_q;          // per-word written markers
    logic [15:0] rd_q;            // registered read data

    // markers: reset and clear empty the buffer; write marks the word
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || b.clr) begin
            used_q <= 64'h0;
        end else if (b.wr && !used_q[b.wa]) begin
            used_q[b.wa] <= 1'b1;  // word may be written once
        end
    end

    // storage and read register, no reset needed for data
    always_ff @(posedge core_clk_i) begin
        if (b.wr && !used_q[b.wa]) begin
            mem[b.wa] <= b.wd;
        end
        rd_q <= used_q[b.ra] ? mem[b.ra] : 16'hffff;  // erased words read ones
    end

    assign b.rd = rd_q;
    assign b.used = used_q[b.wa];
endmodule
`default_nettype wire

// [logic/fspc_ctrl.sv]
/*
 * flash self-programming controller top: control register, pointer,
 * data pair, command window, buffer loading, erase/write sequencing,
 * busy flag, lock setting and lock/fuse readback.
 * assumes an apb master, a core that pulses store/load strobes, and a
 * flash array outside that takes the erase/write pulses.
 */
// Decided for this implementation: the register addresses and the APB interface to the registers.
`default_nettype none
`include "fspc_consts.svh"
module fspc_ctrl #(
    parameter int unsigned PROG_CYC = `FSPC_PROG_CYC  // programming clocks
) (
    input wire logic core_clk_i,         // 40 mhz clock
    input wire logic sys_rst_i,          // sync reset, high
    input wire logic psel_i,             // apb select
    input wire logic penable_i,          // apb enable
    input wire logic pwrite_i,           // apb direction
    input wire logic [11:0] paddr_i,     // apb byte address
    input wire logic [31:0] pwdata_i,    // apb write data
    output logic [31:0] prdata_o,        // apb read data
    output logic pready_o,               // apb ready
    output logic pslverr_o,              // apb error
    input wire logic store_i,            // core store-program pulse
    input wire logic load_i,             // core load-program pulse
    output logic [7:0] load_data_o,      // lock/fuse readback
    output logic load_valid_o,           // readback taken over load
    input wire logic gie_i,              // global interrupt flag
    input wire logic ee_busy_i,          // data-eeprom write in progress
    input wire logic boot_fuse_i,        // boot-reset fuse, 0 programmed
    input wire logic [7:0] fuse_lo_i,    // fuse low bits
    input wire logic [7:0] fuse_hi_i,    // fuse high bits
    output logic [15:0] reset_vec_o,     // reset fetch address
    output logic irq_o,                  // ready interrupt request
    output logic core_halt_o,            // stall core
    output logic section_blocked_o,      // concurrent section unreadable
    output logic erase_o,                // page erase pulse to array
    output logic write_o,                // page write pulse to array
    output logic [6:0] page_o,           // latched target page
    output logic [5:0] buf_ra_o,         // buffer read index for array
    output logic [15:0] buf_rd_o         // buffer read word for array
);
    fspc_buf_if bi ();  // buffer carrier

    typedef struct packed {
        fspc_pkg::fspc_state_e st;  // sequencer state
        logic [7:0] ctrl;           // store_program_control
        logic [15:0] ptr;           // address pointer
        logic [15:0] data;          // data_register_pair
        logic [7:0] lock;           // boot lock bits
        logic [2:0] win;            // window counter
        logic [6:0] page;           // latched page
        logic halt;                 // halting-section operation
        logic [31:0] tmr;           // programming timer
        logic was_load;             // buffer load seen since clear
        logic [7:0] ld;             // readback data
        logic ldv;                  // readback valid
        logic [15:0] rvec;          // reset vector
        logic rvec_ok;              // vector captured
        logic ers;                  // erase pulse
        logic wrp;                  // write pulse
        logic [31:0] rdat;          // apb read data
    } fspc_ctrl_s;

    fspc_ctrl_s s_q, s_d;  // state and next

    // page field of a pointer value
    function automatic logic [6:0] page_of(input logic [15:0] p);
        page_of = p[`FSPC_PAGE_LSB +: `FSPC_PAGE_W];
    endfunction

    // apb access phase; zero wait states so ready is simply high
    logic acc;  // completing transfer
    logic wr_ctrl;  // software writes control
    logic [4:0] cmd;  // written low five bits
    logic [4:0] arm;  // armed command
    assign acc = psel_i && penable_i;
    assign wr_ctrl = acc && pwrite_i && paddr_i == `FSPC_OFS_CTRL;
    assign cmd = pwdata_i[4:0];
    assign arm = s_q.ctrl[4:0];

    // next-state logic
    always_comb begin
        s_d = s_q;
        s_d.ers = 1'b0;
        s_d.wrp = 1'b0;
        s_d.ldv = 1'b0;
        bi.wr = 1'b0;
        bi.clr = 1'b0;
        bi.wa = s_q.ptr[`FSPC_WORD_LSB +: `FSPC_WORD_W];
        bi.wd = s_q.data;
        // reset vector caught once after release
        if (!s_q.rvec_ok) begin
            s_d.rvec = boot_fuse_i ? `FSPC_RESET_ADDR : `FSPC_BOOT_ADDR;
            s_d.rvec_ok = 1'b1;
        end
        // plain register writes
        if (acc && pwrite_i) begin
            case (paddr_i)
                `FSPC_OFS_PTR: s_d.ptr = pwdata_i[15:0];
                `FSPC_OFS_DATA: s_d.data = pwdata_i[15:0];
                default: ;
            endcase
        end
        // interrupt enable always writable; bit6 hardware only
        if (wr_ctrl) begin
            s_d.ctrl[`FSPC_B_IE] = pwdata_i[`FSPC_B_IE];
        end
        case (s_q.st)
            fspc_pkg::FSPC_IDLE: begin
                // eeprom write blocks new commands
                if (wr_ctrl && !ee_busy_i) begin
                    // only the five defined codes arm
                    if (cmd == `FSPC_CMD_LOAD || cmd == `FSPC_CMD_ERASE ||
                        cmd == `FSPC_CMD_WRITE || cmd == `FSPC_CMD_LSET ||
                        cmd == `FSPC_CMD_REEN) begin
                        s_d.ctrl[4:0] = cmd;
                        s_d.win = `FSPC_STORE_WIN;
                        s_d.st = fspc_pkg::FSPC_ARMED;
                        // re-enable while loading drops the buffer
                        if (cmd == `FSPC_CMD_REEN && s_q.was_load) begin
                            bi.clr = 1'b1;
                            s_d.was_load = 1'b0;
                        end
                    end
                end
            end
            fspc_pkg::FSPC_ARMED: begin
                s_d.win = s_q.win - 3'h1;
                // lock/fuse readback within three cycles
                if (load_i && arm == `FSPC_CMD_LSET && !ee_busy_i &&
                    (`FSPC_STORE_WIN - s_q.win) < `FSPC_LOAD_WIN) begin
                    // pointer bit zero picks lock or fuse
                    s_d.ld = s_q.ptr[0] ? s_q.lock :
                             (s_q.ptr[1] ? fuse_hi_i : fuse_lo_i);
                    s_d.ldv = 1'b1;
                    s_d.ctrl[4:0] = 5'h00;
                    s_d.st = fspc_pkg::FSPC_IDLE;
                end else if (store_i && !ee_busy_i) begin
                    s_d.ctrl[4:0] = 5'h00;  // auto-clear on completion
                    s_d.st = fspc_pkg::FSPC_IDLE;
                    case (arm)
                        `FSPC_CMD_LOAD: begin
                            // word selected by pointer, bit 0 ignored
                            bi.wr = 1'b1;
                            s_d.was_load = 1'b1;
                            s_d.ctrl[`FSPC_B_BUSY] = 1'b0;
                        end
                        `FSPC_CMD_LSET: begin
                            // low byte only, pointer ignored; program zeros
                            s_d.lock = s_q.lock & s_q.data[7:0];
                        end
                        `FSPC_CMD_REEN: begin
                            s_d.ctrl[`FSPC_B_BUSY] = 1'b0;  // idle, so legal
                            bi.clr = 1'b1;
                            s_d.was_load = 1'b0;
                        end
                        `FSPC_CMD_ERASE, `FSPC_CMD_WRITE: begin
                            // latch page now, pointer free afterwards
                            s_d.page = page_of(s_q.ptr);
                            s_d.halt = page_of(s_q.ptr) >= `FSPC_HALT_PAGE;
                            if (page_of(s_q.ptr) < `FSPC_HALT_PAGE) begin
                                s_d.ctrl[`FSPC_B_BUSY] = 1'b1;
                            end
                            s_d.ctrl[4:0] = arm;  // enable stays high
                            s_d.ers = arm == `FSPC_CMD_ERASE;
                            s_d.wrp = arm == `FSPC_CMD_WRITE;
                            s_d.tmr = PROG_CYC;
                            s_d.st = fspc_pkg::FSPC_BUSY;
                        end
                        default: ;
                    endcase
                end else if (s_q.win == 3'h1) begin
                    s_d.ctrl[4:0] = 5'h00;  // no store in window
                    s_d.st = fspc_pkg::FSPC_IDLE;
                end
            end
            fspc_pkg::FSPC_BUSY: begin
                // re-enable attempts are ignored here
                s_d.tmr = s_q.tmr - 32'h1;
                if (s_q.tmr == 32'h1) begin
                    if (arm == `FSPC_CMD_WRITE) begin
                        bi.clr = 1'b1;  // buffer empties after write
                        s_d.was_load = 1'b0;
                    end
                    s_d.ctrl[4:0] = 5'h00;  // command and enable clear
                    s_d.halt = 1'b0;
                    s_d.st = fspc_pkg::FSPC_IDLE;
                end
            end
            default: s_d.st = fspc_pkg::FSPC_IDLE;
        endcase
        // eeprom write during loading loses the buffer
        if (ee_busy_i && s_q.was_load) begin
            bi.clr = 1'b1;
            s_d.was_load = 1'b0;
        end
        s_d.ctrl[5] = 1'b0;  // reserved reads zero
        // apb read data registered at setup, presented in access
        s_d.rdat = 32'h0;
        if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                `FSPC_OFS_CTRL: s_d.rdat = {24'h0, s_q.ctrl};
                `FSPC_OFS_PTR: s_d.rdat = {16'h0, s_q.ptr};
                `FSPC_OFS_DATA: s_d.rdat = {16'h0, s_q.data};
                `FSPC_OFS_LOCK: s_d.rdat = {24'h0, s_q.lock};
                `FSPC_OFS_STAT: s_d.rdat = {28'h0, s_q.halt, s_q.was_load, s_q.st};
                `FSPC_OFS_LOAD: s_d.rdat = {24'h0, s_q.ld};
                default: s_d.rdat = 32'h0;
            endcase
        end
    end

    // state register, constants only under reset
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
            s_q.ctrl <= `FSPC_CTRL_RST;
            s_q.lock <= `FSPC_LOCK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // page buffer memory
    fspc_page_buf u_buf (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .b(bi)
    );

    assign bi.ra = buf_ra_o;
    // unmapped addresses error; pready always high (no wait states)
    assign pready_o = 1'b1;
    assign pslverr_o = acc && !(paddr_i == `FSPC_OFS_CTRL || paddr_i == `FSPC_OFS_PTR ||
        paddr_i == `FSPC_OFS_DATA || paddr_i == `FSPC_OFS_LOCK ||
        paddr_i == `FSPC_OFS_STAT || paddr_i == `FSPC_OFS_LOAD);
    assign prdata_o = s_q.rdat;
    assign load_data_o = s_q.ld;
    assign load_valid_o = s_q.ldv;
    assign reset_vec_o = s_q.rvec;
    // level request while enable clear
    assign irq_o = s_q.ctrl[`FSPC_B_IE] && gie_i && !s_q.ctrl[`FSPC_B_EN];
    assign core_halt_o = s_q.halt;
    assign section_blocked_o = s_q.ctrl[`FSPC_B_BUSY];
    assign erase_o = s_q.ers;
    assign write_o = s_q.wrp;
    assign page_o = s_q.page;
    assign buf_ra_o = 6'h00;
    assign buf_rd_o = bi.rd;
endmodule
`default_nettype wire

// [sim/fspc_core_model.sv]
/*
 * core model: store and load program pulses.
 * assumes one request at a time.
 */
`default_nettype none
module fspc_core_model (
    input wire logic core_clk_i,   // system clock
    input wire logic sys_rst_i,    // sync reset
    input wire logic start_i,      // issue one instruction
    input wire logic kind_i,       // 0 store, 1 load
    input wire logic [1:0] dly_i,  // extra clocks before issue
    output logic store_o,          // store-program pulse
    output logic load_o            // load-program pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_q;  // clocks left before issue
    logic kind_q;       // instruction kind held
    // one-clock pulse; a long delay lets the arm window lapse
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= 3'h0;
            kind_q <= 1'b0;
        end else if (start_i) begin
            cnt_q <= {1'b0, dly_i} + 3'h1;
            kind_q <= kind_i;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    // store lands within four clocks of the command write when dly_i is at most 2
    assign store_o = (cnt_q == 3'h1) && !kind_q;
    assign load_o = (cnt_q == 3'h1) && kind_q;
endmodule
`default_nettype wire

// [sim/fspc_ctrl_checker.sv]
/*
 * port checker, bound into the controller top.
 * assumes one clock and sync high reset.
 */
`default_nettype none
`include "fspc_consts.svh"
module fspc_ctrl_checker #(
    parameter int unsigned PROG_CYC = 20  // programming clocks
) (
    input wire logic core_clk_i,         // clock
    input wire logic sys_rst_i,          // reset
    input wire logic load_i,             // load pulse
    input wire logic gie_i,              // global flag
    input wire logic ee_busy_i,          // eeprom busy
    input wire logic boot_fuse_i,        // boot fuse
    input wire logic load_valid_o,       // readback pulse
    input wire logic [15:0] reset_vec_o, // reset vector
    input wire logic irq_o,              // ready interrupt
    input wire logic core_halt_o,        // core stall
    input wire logic section_blocked_o,  // busy flag
    input wire logic erase_o,            // erase pulse
    input wire logic write_o,            // write pulse
    input wire logic [6:0] page_o        // latched page
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] hcnt_q;  // clocks of the current stall
    logic [31:0] hcnt_d;  // next stall count
    // counter keeps the long stall out of a repetition
    assign hcnt_d = core_halt_o ? hcnt_q + 32'h1 : 32'h0;
    always_ff @(posedge core_clk_i) begin
        hcnt_q <= sys_rst_i ? 32'h0 : hcnt_d;
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    property p_reset_vec;
        !$past(sys_rst_i, 2) && !$past(sys_rst_i) |->
            reset_vec_o == (boot_fuse_i ? `FSPC_RESET_ADDR : `FSPC_BOOT_ADDR);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");
    property p_irq;
        irq_o |-> gie_i;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without global flag");
    property p_erase_pulse;
        erase_o |=> !erase_o;
    endproperty
    a_erase_pulse: assert property (p_erase_pulse) else $error("erase pulse long");
    property p_write_pulse;
        write_o |=> !write_o && !erase_o;
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("write pulse long");
    property p_halt_page;
        core_halt_o |-> page_o >= `FSPC_HALT_PAGE && !$rose(section_blocked_o);
    endproperty
    a_halt_page: assert property (p_halt_page) else $error("stall on wrong page");
    property p_blk_page;
        $rose(section_blocked_o) |-> page_o < `FSPC_HALT_PAGE && !core_halt_o;
    endproperty
    a_blk_page: assert property (p_blk_page) else $error("busy on wrong page");
    property p_page_hold;
        core_halt_o && $past(core_halt_o) |-> $stable(page_o);
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("page moved in op");
    property p_load_valid;
        load_valid_o |-> $past(load_i);
    endproperty
    a_load_valid: assert property (p_load_valid) else $error("readback uncaused");
    property p_ee_block;
        erase_o || write_o || load_valid_o |-> !$past(ee_busy_i);
    endproperty
    a_ee_block: assert property (p_ee_block) else $error("op during eeprom");
    property p_halt_len;
        $fell(core_halt_o) |-> hcnt_q + 1 >= PROG_CYC && hcnt_q <= PROG_CYC + 1;
    endproperty
    a_halt_len: assert property (p_halt_len) else $error("stall length wrong");
    c_erase: cover property (erase_o);
    c_write: cover property (write_o);
    c_halt: cover property ($fell(core_halt_o));
    c_load: cover property (load_valid_o);
endmodule
bind fspc_ctrl fspc_ctrl_checker #(.PROG_CYC(PROG_CYC)) u_chk (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .load_i(load_i), .gie_i(gie_i),
    .ee_busy_i(ee_busy_i), .boot_fuse_i(boot_fuse_i), .load_valid_o(load_valid_o),
    .reset_vec_o(reset_vec_o), .irq_o(irq_o), .core_halt_o(core_halt_o),
    .section_blocked_o(section_blocked_o), .erase_o(erase_o), .write_o(write_o),
    .page_o(page_o));
`default_nettype wire

// [sim/flash_self_programming_control_tb.sv]
/*
 * bench: apb register tasks plus a core model.
 * assumes a programming time cut to 20 clocks.
 */
`default_nettype none
`include "fspc_consts.svh"
module flash_self_programming_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err, gie = 1'b1;
    logic ee = 1'b0, start = 1'b0, kind = 1'b0, store, load, pready, pslverr, lval;
    logic irq, halt, blk, er, wr, fuse = 1'b0;
    logic [1:0] dly = 2'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] ldata;
    logic [15:0] rvec, brd;
    logic [6:0] page;
    int fails = 0, cmp_count = 0;
    logic [31:0] ptrs [3] = '{32'h1, 32'h0, 32'h2};  // lock, fuse low, fuse high
    logic [31:0] exps [3] = '{32'hc3, 32'h5a, 32'ha5};
    logic [4:0] codes [4] = '{5'h02, 5'h07, 5'h0f, 5'h1f};  // undefined codes
    initial forever #12.5 clk = ~clk;
    fspc_ctrl #(.PROG_CYC(20)) uut (
        .core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .store_i(store), .load_i(load), .load_data_o(ldata),
        .load_valid_o(lval), .gie_i(gie), .ee_busy_i(ee), .boot_fuse_i(fuse),
        .fuse_lo_i(8'h5a), .fuse_hi_i(8'ha5), .reset_vec_o(rvec), .irq_o(irq),
        .core_halt_o(halt), .section_blocked_o(blk), .erase_o(er), .write_o(wr),
        .page_o(page), .buf_ra_o(), .buf_rd_o(brd));
    fspc_core_model u_core (.core_clk_i(clk), .sys_rst_i(rst), .start_i(start),
        .kind_i(kind), .dly_i(dly), .store_o(store), .load_o(load));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one apb transfer; released only after pready is seen in the access phase
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // ask the core model for one instruction, then let it land
    task automatic core(input logic k, input logic [1:0] d);
        start <= 1'b1;
        kind <= k;
        dly <= d;
        @(posedge clk);
        start <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // poll store enable until it drops, bounded
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 100);
        if (n >= 100) begin
            fails++;
            stop_test();
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h0);
        check("reset vector", {16'h0, rvec}, {16'h0, `FSPC_BOOT_ADDR});
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b1, `FSPC_OFS_CTRL, 32'he0);
        apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
        check("ctrl ro bits", rd, 32'h80);
        check("irq on", {31'h0, irq}, 32'h1);
        gie <= 1'b0;
        @(posedge clk);
        check("irq gated", {31'h0, irq}, 32'h0);
        gie <= 1'b1;
        apb(1'b1, `FSPC_OFS_CTRL, 32'h0);
        foreach (codes[i]) begin
            apb(1'b1, `FSPC_OFS_CTRL, {27'h0, codes[i]});
            apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
            check("ctrl undefined", rd, 32'h0);
        end
        apb(1'b1, `FSPC_OFS_CTRL, 32'h1);
        apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
        check("ctrl armed", rd, 32'h1);
        apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
        check("ctrl lapsed", rd, 32'h0);
        apb(1'b1, `FSPC_OFS_DATA, 32'h1234);
        apb(1'b1, `FSPC_OFS_CTRL, 32'h1);
        core(1'b0, 2'h1);
        check("buffer load", {16'h0, brd}, 32'h1234);
        apb(1'b1, `FSPC_OFS_PTR, 32'h1);
        apb(1'b1, `FSPC_OFS_DATA, 32'h5678);
        apb(1'b1, `FSPC_OFS_CTRL, 32'h1);
        core(1'b0, 2'h0);
        check("buffer once", {16'h0, brd}, 32'h1234);
        apb(1'b1, `FSPC_OFS_CTRL, 32'h11);
        core(1'b0, 2'h0);
        check("buffer cleared", {16'h0, brd}, 32'hffff);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `FSPC_OFS_PTR, 32'h0180);
            apb(1'b1, `FSPC_OFS_CTRL, 32'h3);
            core(1'b0, 2'h0);
            check("busy set", {31'h0, blk}, 32'h1);
            check("no stall", {31'h0, halt}, 32'h0);
            apb(1'b1, `FSPC_OFS_PTR, 32'h0);
            apb(1'b1, `FSPC_OFS_CTRL, 32'h11);
            apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
            check("ctrl in op", rd, 32'h43);
            check("page latched", {25'h0, page}, 32'h3);
            wait_idle();
            check("ctrl done", rd, 32'h40);
            check("still busy", {31'h0, blk}, 32'h1);
            apb(1'b1, `FSPC_OFS_CTRL, i == 0 ? 32'h11 : 32'h1);
            core(1'b0, 2'h0);
            check("busy cleared", {31'h0, blk}, 32'h0);
        end
        apb(1'b1, `FSPC_OFS_PTR, 32'h3800);
        apb(1'b1, `FSPC_OFS_CTRL, 32'h5);
        core(1'b0, 2'h0);
        check("stall", {31'h0, halt}, 32'h1);
        check("write page", {25'h0, page}, 32'h70);
        wait_idle();
        check("ctrl after write", rd, 32'h0);
        check("buffer after write", {16'h0, brd}, 32'hffff);
        apb(1'b1, `FSPC_OFS_DATA, 32'hffc3);
        apb(1'b1, `FSPC_OFS_PTR, 32'hffff);
        apb(1'b1, `FSPC_OFS_CTRL, 32'h9);
        core(1'b0, 2'h0);
        apb(1'b0, `FSPC_OFS_LOCK, 32'h0);
        check("lock bits", rd, 32'hc3);
        foreach (ptrs[i]) begin
            apb(1'b1, `FSPC_OFS_PTR, ptrs[i]);
            apb(1'b1, `FSPC_OFS_CTRL, 32'h9);
            core(1'b1, 2'h0);
            check("readback", {24'h0, ldata}, exps[i]);
        end
        apb(1'b1, `FSPC_OFS_PTR, 32'h0);
        apb(1'b1, `FSPC_OFS_CTRL, 32'h1);
        core(1'b0, 2'h0);
        ee <= 1'b1;
        apb(1'b1, `FSPC_OFS_CTRL, 32'h3);
        apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
        check("ctrl eeprom", rd, 32'h0);
        ee <= 1'b0;
        check("buffer eeprom", {16'h0, brd}, 32'hffff);
        fuse <= 1'b1;
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check("vector fuse off", {16'h0, rvec}, {16'h0, `FSPC_RESET_ADDR});
        stop_test();
    end
endmodule
`default_nettype wire
